//--- ctm_timer.sv
// Purpose: Cascaded 16-bit period timer with APB register access.
// Assumes: pclk is the oscillator clock; external pin is asynchronous.
// Notes: Indices 0x16 and 0x17 are banked through the bank select register.
// Contract
// - Cascade bit joins bytes into 16-bit counter
// - Cascaded count increments, compares with 16-bit period
// - Tick after match clears count, sets flag
// - Pair clock bit alone selects cascaded clock
// - Pair clock clear: count each instruction cycle
// - Pair clock set: count on pin falling edge
// - Both enables run 16-bit; low alone low byte
// - Pin sampled twice per instruction, synchronised
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ctm_timer #(
  parameter int ADDR_W = 8 // APB address width
) (
  input wire logic pclk, // System clock, 20 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data, registered
  output logic pready, // APB ready, registered
  output logic pslverr, // APB error on unmapped address
  input wire logic external_count_pin, // External count clock pin
  output logic irq // Level interrupt request
);

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_COUNT_LOW = 3'h1,
    SEL_COUNT_HIGH = 3'h3,
    SEL_PERIOD_LOW = 3'h2,
    SEL_PERIOD_HIGH = 3'h6,
    SEL_CONFIG = 3'h7,
    SEL_RUN = 3'h5,
    SEL_FLAG = 3'h4
  } ctm_sel_e;

  logic instr_tick;
  logic sample_tick;
  logic pin_fall;

  logic [7:0] cnt_lo_r;
  logic [7:0] cnt_hi_r;
  logic [7:0] per_lo_r;
  logic [7:0] per_hi_r;
  ctm_pkg::ctm_cfg_s cfg_r;
  ctm_pkg::ctm_run_s run_r;
  logic [7:0] flag_r;
  logic [7:0] ena_r;
  logic [1:0] bank_r;
  logic [7:0] rd_flags_r;

  logic [7:0] cnt_lo_nxt;
  logic [7:0] cnt_hi_nxt;
  logic [7:0] per_lo_nxt;
  logic [7:0] per_hi_nxt;
  ctm_pkg::ctm_cfg_s cfg_nxt;
  ctm_pkg::ctm_run_s run_nxt;
  logic [7:0] flag_nxt;
  logic [7:0] ena_nxt;
  logic [1:0] bank_nxt;
  logic [7:0] rd_flags_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;
  logic irq_nxt;

  logic [7:0] flag_set;
  logic [15:0] cnt16;
  logic [15:0] per16;
  logic lo_tick;
  logic hi_tick;
  logic cascaded;
  logic setup;
  logic commit;
  logic [7:0] wbyte;
  ctm_sel_e sel;
  logic sel_ena;

  // One clock only: slower rates arrive as single-cycle enables
  ctm_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .instr_tick(instr_tick),
    .sample_tick(sample_tick)
  );

  ctm_edge_sync u_edge_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(external_count_pin),
    .sample_tick(sample_tick),
    .fall_pulse(pin_fall)
  );

  // Decode index and bank into a register select
  function automatic ctm_sel_e decode(input logic [5:0] idx, input logic [1:0] bank);
    ctm_sel_e s;
    s = SEL_NONE;
    case (idx)
      ctm_pkg::IDX_COUNT_LOW: s = SEL_COUNT_LOW;
      ctm_pkg::IDX_COUNT_HIGH: s = SEL_COUNT_HIGH;
      ctm_pkg::IDX_PERIOD_LOW: s = SEL_PERIOD_LOW;
      ctm_pkg::IDX_PERIOD_HIGH: s = SEL_PERIOD_HIGH;
      ctm_pkg::IDX_BANK_16: begin
        if (bank == ctm_pkg::BANK_TIMER) begin
          s = SEL_CONFIG;
        end else if (bank == ctm_pkg::BANK_FLAGS) begin
          s = SEL_FLAG;
        end
      end
      ctm_pkg::IDX_BANK_17: begin
        if (bank == ctm_pkg::BANK_TIMER) begin
          s = SEL_RUN;
        end
      end
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction : decode

  // Enable bank shares index 0x17 with run control; kept apart from the enum
  function automatic logic is_enable(input logic [5:0] idx, input logic [1:0] bank);
    return (idx == ctm_pkg::IDX_BANK_17) && (bank == ctm_pkg::BANK_FLAGS);
  endfunction : is_enable

  // Address and tick qualification
  always_comb begin
    setup = psel & ~penable;
    commit = psel & penable & pready;
    wbyte = pwdata[7:0];
    sel = decode(paddr[7:2], bank_r);
    sel_ena = is_enable(paddr[7:2], bank_r);
    cnt16 = {cnt_hi_r, cnt_lo_r};
    per16 = {per_hi_r, per_lo_r};
    cascaded = cfg_r.cascade_select & run_r.low_run_enable & run_r.high_run_enable;
    lo_tick = cfg_r.pair_clock_source ? pin_fall : instr_tick;
    hi_tick = cfg_r.upper_clock_source ? pin_fall : instr_tick;
  end

  // Counting and matching
  always_comb begin
    cnt_lo_nxt = cnt_lo_r;
    cnt_hi_nxt = cnt_hi_r;
    flag_set = 8'h00;
    // Match is tested before the increment, so the period value itself is counted
    if (cascaded) begin
      if (lo_tick) begin
        if (cnt16 == per16) begin
          {cnt_hi_nxt, cnt_lo_nxt} = 16'h0000;
          flag_set[ctm_pkg::FLAG_POS_LOW_MATCH] = 1'b1;
        end else begin
          {cnt_hi_nxt, cnt_lo_nxt} = cnt16 + 16'h0001;
        end
      end
    end else begin
      // Low byte alone runs whenever its enable is set
      if (run_r.low_run_enable && lo_tick) begin
        if (cnt_lo_r == per_lo_r) begin
          cnt_lo_nxt = 8'h00;
          flag_set[ctm_pkg::FLAG_POS_LOW_MATCH] = 1'b1;
        end else begin
          cnt_lo_nxt = cnt_lo_r + 8'h01;
        end
      end
      // Upper byte runs on its own only outside cascade mode
      if (!cfg_r.cascade_select && run_r.high_run_enable && hi_tick) begin
        if (cnt_hi_r == per_hi_r) begin
          cnt_hi_nxt = 8'h00;
          flag_set[ctm_pkg::FLAG_POS_HIGH_MATCH] = 1'b1;
        end else begin
          cnt_hi_nxt = cnt_hi_r + 8'h01;
        end
      end
    end
    // Software write to a count byte overrides the tick in that cycle
    if (commit && pwrite && sel == SEL_COUNT_LOW) begin
      cnt_lo_nxt = wbyte;
    end
    if (commit && pwrite && sel == SEL_COUNT_HIGH) begin
      cnt_hi_nxt = wbyte;
    end
  end

  // Configuration registers
  always_comb begin
    per_lo_nxt = per_lo_r;
    per_hi_nxt = per_hi_r;
    cfg_nxt = cfg_r;
    run_nxt = run_r;
    ena_nxt = ena_r;
    bank_nxt = bank_r;
    // The flag bank has no write path; software clears flags by reading them
    if (commit && pwrite) begin
      case (sel)
        SEL_PERIOD_LOW: per_lo_nxt = wbyte;
        SEL_PERIOD_HIGH: per_hi_nxt = wbyte;
        SEL_CONFIG: cfg_nxt = ctm_pkg::ctm_cfg_s'(wbyte);
        SEL_RUN: run_nxt = ctm_pkg::ctm_run_s'(wbyte);
        default: begin
        end
      endcase
      if (sel_ena) begin
        ena_nxt = wbyte;
      end
      if (paddr[7:2] == ctm_pkg::IDX_BANK_SELECT) begin
        bank_nxt = wbyte[1:0];
      end
    end
  end

  // Sticky flags: a read clears only what it returned, and a new set wins
  always_comb begin
    flag_nxt = flag_r;
    if (commit && !pwrite && sel == SEL_FLAG) begin
      flag_nxt = flag_r & ~rd_flags_r;
    end
    flag_nxt = flag_nxt | flag_set;
    irq_nxt = |(flag_nxt & ena_nxt);
  end

  // APB answer: data and ready are prepared in the setup cycle
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pready_nxt = setup;
    pslverr_nxt = 1'b0;
    rd_flags_nxt = rd_flags_r;
    // Count reads show the value after this edge, so a tick in the setup cycle is seen
    if (setup) begin
      rd_flags_nxt = 8'h00;
      case (sel)
        SEL_COUNT_LOW: prdata_nxt[7:0] = cnt_lo_nxt;
        SEL_COUNT_HIGH: prdata_nxt[7:0] = cnt_hi_nxt;
        SEL_PERIOD_LOW: prdata_nxt[7:0] = per_lo_r;
        SEL_PERIOD_HIGH: prdata_nxt[7:0] = per_hi_r;
        SEL_CONFIG: prdata_nxt[7:0] = cfg_r;
        SEL_RUN: prdata_nxt[7:0] = run_r;
        SEL_FLAG: begin
          prdata_nxt[7:0] = flag_nxt;
          rd_flags_nxt = pwrite ? 8'h00 : flag_nxt;
        end
        default: begin
          if (sel_ena) begin
            prdata_nxt[7:0] = ena_r;
          end else if (paddr[7:2] == ctm_pkg::IDX_BANK_SELECT) begin
            prdata_nxt[1:0] = bank_r;
          end else begin
            pslverr_nxt = 1'b1;
          end
        end
      endcase
    end else if (commit) begin
      // Read data stands one cycle past the access cycle, then returns to zero
      prdata_nxt = prdata;
      pslverr_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lo_r <= ctm_pkg::COUNT_RST;
      cnt_hi_r <= ctm_pkg::COUNT_RST;
      per_lo_r <= ctm_pkg::PERIOD_RST;
      per_hi_r <= ctm_pkg::PERIOD_RST;
      cfg_r <= ctm_pkg::ctm_cfg_s'(ctm_pkg::CFG_RST);
      run_r <= ctm_pkg::ctm_run_s'(ctm_pkg::RUN_RST);
      flag_r <= ctm_pkg::FLAG_RST;
      ena_r <= ctm_pkg::ENA_RST;
      bank_r <= ctm_pkg::BANK_RST;
      rd_flags_r <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      cnt_lo_r <= cnt_lo_nxt;
      cnt_hi_r <= cnt_hi_nxt;
      per_lo_r <= per_lo_nxt;
      per_hi_r <= per_hi_nxt;
      cfg_r <= cfg_nxt;
      run_r <= run_nxt;
      flag_r <= flag_nxt;
      ena_r <= ena_nxt;
      bank_r <= bank_nxt;
      rd_flags_r <= rd_flags_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      irq <= irq_nxt;
    end
  end

endmodule : ctm_timer
`default_nettype wire

//--- ctm_pkg.sv
// Purpose: Shared constants and types of the cascaded period timer.
// Assumes: APB slave, 32-bit data, one word per register index.
// Notes: Byte address of a register is four times its index.
package ctm_pkg;

  // Register indices; byte address = index * 4
  localparam logic [5:0] IDX_COUNT_LOW = 6'h10;
  localparam logic [5:0] IDX_COUNT_HIGH = 6'h11;
  localparam logic [5:0] IDX_PERIOD_LOW = 6'h14;
  localparam logic [5:0] IDX_PERIOD_HIGH = 6'h15;
  localparam logic [5:0] IDX_BANK_16 = 6'h16;
  localparam logic [5:0] IDX_BANK_17 = 6'h17;
  localparam logic [5:0] IDX_BANK_SELECT = 6'h0F;

  // Bank numbers that resolve the shared indices
  localparam logic [1:0] BANK_FLAGS = 2'h1;
  localparam logic [1:0] BANK_TIMER = 2'h3;

  // Values after reset
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RUN_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h02;
  localparam logic [7:0] ENA_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'h00;
  localparam logic [1:0] BANK_RST = 2'h0;

  // Field positions in the flag and enable banks
  localparam int FLAG_POS_LOW_MATCH = 4;
  localparam int FLAG_POS_HIGH_MATCH = 5;

  // Instruction cycle is four pclk cycles; input sampled twice in it
  localparam int CLKS_PER_INSTR = 4;
  localparam int SAMPLES_PER_INSTR = 2;
  localparam int CLKS_PER_SAMPLE = CLKS_PER_INSTR / SAMPLES_PER_INSTR;

  // Clock configuration byte layout, bit 7 first
  typedef struct packed {
    logic [3:0] capture_edges;
    logic cascade_select;
    logic third_clock_source;
    logic upper_clock_source;
    logic pair_clock_source;
  } ctm_cfg_s;

  // Run control byte layout, bit 7 first
  typedef struct packed {
    logic [5:0] other_controls;
    logic high_run_enable;
    logic low_run_enable;
  } ctm_run_s;

endpackage : ctm_pkg

//--- ctm_divider.sv
// Purpose: Instruction-cycle and sample enable pulses from pclk.
// Assumes: pclk is the oscillator; one instruction is four pclk cycles.
// Notes: Both outputs are single-cycle pulses from flip-flops.
`timescale 1ns/100ps
`default_nettype none
module ctm_divider (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  output logic instr_tick, // One pulse per instruction cycle
  output logic sample_tick // Two pulses per instruction cycle
);

  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic instr_nxt;
  logic sample_nxt;

  always_comb begin
    phase_nxt = phase_r + 2'h1;
    instr_nxt = (phase_r == 2'(ctm_pkg::CLKS_PER_INSTR - 1));
    sample_nxt = (phase_r[0] == 1'b1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'h0;
      instr_tick <= 1'b0;
      sample_tick <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      instr_tick <= instr_nxt;
      sample_tick <= sample_nxt;
    end
  end

endmodule : ctm_divider
`default_nettype wire

//--- ctm_edge_sync.sv
// Purpose: Falling-edge detector for the external count pin.
// Assumes: Pin is asynchronous to pclk.
// Notes: Two-flop synchroniser, then sampled at the sample rate.
`timescale 1ns/100ps
`default_nettype none
module ctm_edge_sync (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic pin, // Raw external count pin
  input wire logic sample_tick, // Sample enable, twice per instruction
  output logic fall_pulse // One cycle after a sampled falling edge
);

  logic meta_r;
  logic sync_r;
  logic samp_r;
  logic samp_nxt;
  logic fall_nxt;

  // Pulses narrower than a sample period may be missed; that is the limit
  always_comb begin
    samp_nxt = sample_tick ? sync_r : samp_r;
    fall_nxt = sample_tick & samp_r & ~sync_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      samp_r <= 1'b1;
      fall_pulse <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      samp_r <= samp_nxt;
      fall_pulse <= fall_nxt;
    end
  end

endmodule : ctm_edge_sync
`default_nettype wire

//--- ctm_timer_sva.sv
// Purpose: Port checks for the period timer.
// Assumes: Bound to ctm_timer.
// Notes: One clock domain.
`timescale 1ns/100ps
`default_nettype none
module ctm_timer_sva #(
  parameter int ADDR_W = 8 // Address width
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic [ADDR_W-1:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic irq // Interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  property p_ready_next;
    s_setup |=> s_done;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
  property p_ready_cause;
    pready |-> $past(psel) && !$past(penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_unmapped;
    (psel && !penable && paddr[7:2] == 6'h00) |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_mapped;
    (psel && !penable && paddr[7:2] == 6'h10) |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("count byte refused");
  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_irq_fall;
    $fell(irq) |-> $past(psel) && $past(penable) && $past(pready);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
endmodule : ctm_timer_sva
`default_nettype wire

//--- ctm_pin_src.sv
// Purpose: External count source driving the count pin.
// Assumes: Pin idles high as if pulled up.
// Notes: Low time is set per pulse, short or long.
`timescale 1ns/100ps
`default_nettype none
module ctm_pin_src (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic req, // Start one low pulse
  input wire logic [3:0] low_len, // Low time in clocks
  output logic pin // Count pin
);
  logic [3:0] left_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b1;
      left_r <= 4'h0;
    end else if (req && left_r == 4'h0) begin
      pin <= 1'b0;
      left_r <= low_len;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
      pin <= (left_r == 4'h1);
    end
  end
endmodule : ctm_pin_src
`default_nettype wire

//--- ctm_timer_bench.sv
// Purpose: Self-checking bench for the period timer.
// Assumes: A transfer ends when pready is seen at a rising edge.
// Notes: Bank 1 holds flags and enables, bank 3 the timer controls.
`timescale 1ns/100ps
`default_nettype none
module ctm_timer_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic req = 1'b0;
  logic [3:0] low_len = 4'h3;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, pin, irq;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  always #25 pclk = ~pclk;
  ctm_timer #(.ADDR_W(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_pin(pin), .irq(irq));
  ctm_pin_src src_u (.pclk(pclk), .presetn(presetn), .req(req), .low_len(low_len),
    .pin(pin));
  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask : rdc
  task automatic pulse(input logic [3:0] len);
    @(posedge pclk);
    low_len <= len;
    req <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
  endtask : pulse
  task automatic t_reset;
    rdc(8'h00, 32'h00, 1'b1);
    rdc(8'h58, 32'h00, 1'b1);
    rdc(8'h40, 32'h00, 1'b0);
    wr(8'h3C, 32'h3);
    rdc(8'h58, 32'h00, 1'b0);
    rdc(8'h5C, 32'h00, 1'b0);
    wr(8'h3C, 32'h1);
    rdc(8'h58, 32'h02, 1'b0);
    rdc(8'h58, 32'h00, 1'b0);
    rdc(8'h5C, 32'h00, 1'b0);
    wr(8'h58, 32'hFF);
    rdc(8'h58, 32'h00, 1'b0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_cascade;
    int n;
    wr(8'h5C, 32'h10);
    wr(8'h3C, 32'h3);
    wr(8'h40, 32'hFF);
    wr(8'h50, 32'hFF);
    wr(8'h54, 32'hFF);
    wr(8'h58, 32'h0A);
    wr(8'h5C, 32'h03);
    repeat (24) @(posedge pclk);
    wr(8'h5C, 32'h00);
    rdc(8'h44, 32'h01, 1'b0);
    wr(8'h40, 32'hFE);
    wr(8'h44, 32'h00);
    wr(8'h50, 32'h00);
    wr(8'h54, 32'h01);
    wr(8'h5C, 32'h03);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq !== 1'b1 && n < 40);
    chk({31'h0, n >= 9 && n <= 14}, 32'h1);
    wr(8'h5C, 32'h00);
    repeat (10) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h3C, 32'h1);
    rdc(8'h58, 32'h10, 1'b0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("cascade test done");
  endtask : t_cascade
  task automatic t_low;
    wr(8'h5C, 32'h00);
    wr(8'h3C, 32'h3);
    wr(8'h40, 32'hF0);
    wr(8'h44, 32'h05);
    wr(8'h50, 32'hF2);
    wr(8'h54, 32'h00);
    wr(8'h58, 32'h08);
    wr(8'h5C, 32'h01);
    repeat (40) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h5C, 32'h00);
    rdc(8'h44, 32'h05, 1'b0);
    wr(8'h40, 32'h33);
    wr(8'h5C, 32'h02);
    repeat (20) @(posedge pclk);
    rdc(8'h40, 32'h33, 1'b0);
    wr(8'h3C, 32'h1);
    rdc(8'h58, 32'h10, 1'b0);
    $display("low byte test done");
  endtask : t_low
  task automatic t_ext;
    wr(8'h3C, 32'h3);
    wr(8'h40, 32'h00);
    wr(8'h44, 32'h00);
    wr(8'h50, 32'h03);
    wr(8'h58, 32'h09);
    wr(8'h5C, 32'h03);
    pulse(4'h3);
    rdc(8'h40, 32'h00, 1'b0);
    repeat (12) @(posedge pclk);
    rdc(8'h40, 32'h01, 1'b0);
    pulse(4'h9);
    repeat (16) @(posedge pclk);
    pulse(4'h2);
    repeat (40) @(posedge pclk);
    rdc(8'h40, 32'h03, 1'b0);
    pulse(4'h3);
    repeat (14) @(posedge pclk);
    rdc(8'h40, 32'h00, 1'b0);
    wr(8'h3C, 32'h1);
    rdc(8'h58, 32'h10, 1'b0);
    $display("external clock test done");
  endtask : t_ext
  task automatic t_split;
    wr(8'h5C, 32'h20);
    wr(8'h3C, 32'h3);
    wr(8'h5C, 32'h00);
    wr(8'h58, 32'h00);
    wr(8'h40, 32'h77);
    wr(8'h44, 32'h00);
    wr(8'h54, 32'h02);
    wr(8'h5C, 32'h02);
    repeat (40) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h5C, 32'h00);
    rdc(8'h40, 32'h77, 1'b0);
    wr(8'h3C, 32'h1);
    rdc(8'h58, 32'h20, 1'b0);
    $display("split timer test done");
  endtask : t_split
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cascade();
    t_low();
    t_ext();
    t_split();
    conclude();
  end
endmodule : ctm_timer_bench
bind ctm_timer ctm_timer_sva #(.ADDR_W(ADDR_W)) sva_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));
`default_nettype wire
